// ===== rtl/acc_control.v
// Purpose: control and status logic around an analog voltage comparator
// Assumes: all inputs synchronous to clk_in except cmp_raw_in
// Notes:   registers reached by a strobe port, read data one cycle later
`timescale 1ns/1ns
`include "acc_regs.vh"

module acc_control (
  // clock and reset
  input  wire       clk_in,
  input  wire       resetn_in,
  // register port
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // core context
  input  wire       global_irq_enable_in,
  input  wire       irq_ack_in,
  input  wire       converter_enable_in,
  input  wire       converter_power_reduce_in,
  input  wire [2:0] channel_select_in,
  // analog core
  input  wire       cmp_raw_in,
  output wire       cmp_power_off_out,
  output wire       cmp_pos_bandgap_out,
  output wire       cmp_neg_use_channel_out,
  output wire [2:0] cmp_neg_channel_out,
  // pins
  input  wire       cmp_pos_pin_in,
  input  wire       cmp_neg_pin_in,
  output wire       pos_pin_input_off_out,
  output wire       neg_pin_input_off_out,
  output wire       pos_pin_port_bit_out,
  output wire       neg_pin_port_bit_out,
  // timer and interrupt
  output wire       capture_trigger_out,
  output wire       capture_route_out,
  output wire       irq_out
);

  // register contents
  wire [7:0] ctrl_q;
  wire [7:0] conv_b_q;
  wire [1:0] pin_dis_q;
  wire [1:0] mode;

  // comparator level, its edges and the sticky flag
  wire       cmp_sync;
  wire       rise;
  wire       fall;
  wire       edge_hit;
  wire       flag_q;
  wire       flag_clear;
  reg  [7:0] rd_mux;

  // write decodes, one per register
  wire       wr_ctrl;
  wire       wr_conv;
  wire       wr_pin;

  assign wr_ctrl = wr_in && (addr_in == `ACC_OFS_CTRL_STAT);
  assign wr_conv = wr_in && (addr_in == `ACC_OFS_CONV_B);
  assign wr_pin  = wr_in && (addr_in == `ACC_OFS_PIN_DIS);
  assign mode    = ctrl_q[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO];

  // control and status: result and flag bits are not stored here
  acc_field_reg #(
    .WIDTH     (8),
    .WMASK     (`ACC_CTRL_WMASK),
    .RESET_VAL (`ACC_CTRL_RESET)
  ) u_acc_field_reg_ctrl (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .wr_in     (wr_ctrl),
    .wdata_in  (wdata_in),
    .q_out     (ctrl_q)
  );

  // converter control b keeps only the mux enable and trigger bits
  acc_field_reg #(
    .WIDTH     (8),
    .WMASK     (`ACC_CONV_B_WMASK),
    .RESET_VAL (`ACC_CONV_B_RESET)
  ) u_acc_field_reg_conv_b (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .wr_in     (wr_conv),
    .wdata_in  (wdata_in),
    .q_out     (conv_b_q)
  );

  // pin input-off bits, one per comparator pin
  acc_field_reg #(
    .WIDTH     (2),
    .WMASK     (`ACC_PIN_DIS_WMASK),
    .RESET_VAL (`ACC_PIN_DIS_RESET)
  ) u_acc_field_reg_pin_dis (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .wr_in     (wr_pin),
    .wdata_in  (wdata_in[1:0]),
    .q_out     (pin_dis_q)
  );

  // raw level crosses into the clock domain
  acc_sync #(
    .STAGES    (`ACC_SYNC_STAGES)
  ) u_acc_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (cmp_raw_in),
    .sync_out  (cmp_sync)
  );

  // edges held off until the previous sample is a real one
  acc_edge_detect #(
    .PRIME     (`ACC_PRIME_EDGES)
  ) u_acc_edge_detect (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .level_in  (cmp_sync),
    .rise_out  (rise),
    .fall_out  (fall)
  );

  // mode picks which edges count
  acc_event_select u_acc_event_select (
    .mode_in   (mode),
    .rise_in   (rise),
    .fall_in   (fall),
    .hit_out   (edge_hit)
  );

  // vector taken or a written one clears; an edge in that cycle wins
  assign flag_clear = irq_ack_in
                      | (wr_ctrl & wdata_in[`ACC_BIT_FLAG]);

  acc_sticky_flag u_acc_sticky_flag (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (edge_hit),
    .clear_in  (flag_clear),
    .flag_out  (flag_q)
  );

  // read path
  always @* begin
    case (addr_in)
      `ACC_OFS_CTRL_STAT: begin
        rd_mux = ctrl_q;
        rd_mux[`ACC_BIT_RESULT] = cmp_sync;
        rd_mux[`ACC_BIT_FLAG]   = flag_q;
      end
      `ACC_OFS_CONV_B: rd_mux = conv_b_q;
      `ACC_OFS_PIN_DIS: rd_mux = {6'h00, pin_dis_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // analog core, pins and timer
  assign cmp_power_off_out   = ctrl_q[`ACC_BIT_POWER_OFF];
  assign cmp_pos_bandgap_out = ctrl_q[`ACC_BIT_BANDGAP];
  assign cmp_neg_use_channel_out = conv_b_q[`ACC_BIT_MUX_EN]
                                   & ~converter_enable_in
                                   & ~converter_power_reduce_in;
  assign cmp_neg_channel_out   = channel_select_in;
  assign pos_pin_input_off_out = pin_dis_q[0];
  assign neg_pin_input_off_out = pin_dis_q[1];
  assign pos_pin_port_bit_out  = cmp_pos_pin_in & ~pin_dis_q[0];
  assign neg_pin_port_bit_out  = cmp_neg_pin_in & ~pin_dis_q[1];
  assign capture_route_out   = ctrl_q[`ACC_BIT_CAPTURE];
  assign capture_trigger_out = cmp_sync & ctrl_q[`ACC_BIT_CAPTURE];
  assign irq_out = flag_q & ctrl_q[`ACC_BIT_IRQ_EN] & global_irq_enable_in;

endmodule // acc_control

// write-enabled register; bits outside the mask are never stored
module acc_field_reg #(
  parameter             WIDTH     = 8,
  parameter [WIDTH-1:0] WMASK     = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             resetn_in,
  // write port
  input  wire             wr_in,
  input  wire [WIDTH-1:0] wdata_in,
  // stored value
  output reg  [WIDTH-1:0] q_out
);

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_out <= RESET_VAL;
    end else if (wr_in) begin
      q_out <= wdata_in & WMASK;
    end
  end

endmodule // acc_field_reg

// level synchroniser; each stage reads only the stage before it
module acc_sync #(
  parameter STAGES = 2
) (
  // clock and reset
  input  wire clk_in,
  input  wire resetn_in,
  // level from another domain and its synchronised copy
  input  wire async_in,
  output wire sync_out
);

  reg [STAGES-1:0] chain_reg;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chain_reg <= {STAGES{1'b0}};
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_reg[STAGES-1];

endmodule // acc_sync

// edge finder on a synchronised level; samples taken before the chain
// has filled are not trusted, so no false edge follows reset
module acc_edge_detect #(
  parameter PRIME = 3
) (
  // clock and reset
  input  wire clk_in,
  input  wire resetn_in,
  // level and its edges
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);

  reg             prev_reg;
  reg [PRIME-1:0] prime_reg;
  wire            armed;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_reg  <= 1'b0;
      prime_reg <= {PRIME{1'b0}};
    end else begin
      prev_reg  <= level_in;
      prime_reg <= {prime_reg[PRIME-2:0], 1'b1};
    end
  end

  assign armed    = prime_reg[PRIME-1];
  assign rise_out =  level_in & ~prev_reg & armed;
  assign fall_out = ~level_in &  prev_reg & armed;

endmodule // acc_edge_detect

// picks which edges of the level raise the event
module acc_event_select (
  // chosen mode and the edges seen
  input  wire [1:0] mode_in,
  input  wire       rise_in,
  input  wire       fall_in,
  // event for the sticky flag
  output reg        hit_out
);

  always @* begin
    case (mode_in)
      `ACC_MODE_TOGGLE: hit_out = rise_in | fall_in;
      `ACC_MODE_FALL:   hit_out = fall_in;
      `ACC_MODE_RISE:   hit_out = rise_in;
      // reserved mode never flags
      default:          hit_out = 1'b0;
    endcase
  end

endmodule // acc_event_select

// sticky event flag: a set wins over a clear in the same cycle
module acc_sticky_flag (
  // clock and reset
  input  wire clk_in,
  input  wire resetn_in,
  // set and clear requests
  input  wire set_in,
  input  wire clear_in,
  // flag
  output wire flag_out
);

  reg flag_reg;
  reg flag_next;

  always @* begin
    flag_next = flag_reg;
    if (clear_in) begin
      flag_next = 1'b0;
    end
    if (set_in) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule // acc_sticky_flag

// ===== shared/acc_regs.vh
// Purpose: register map and field positions of the comparator control block
// Assumes: 8-bit registers behind a plain strobe port
// Notes:   byte offsets as seen on the register port
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
`define ACC_ADDR_W          8
`define ACC_OFS_CTRL_STAT   8'h50
`define ACC_OFS_CONV_B      8'h7b
`define ACC_OFS_PIN_DIS     8'h7f
`define ACC_OFS_IRQ_MASK    8'h80
`define ACC_CTRL_RESET      8'h00
`define ACC_CONV_B_RESET    8'h00
`define ACC_PIN_DIS_RESET   2'h0
`define ACC_CTRL_WMASK      8'hcf
`define ACC_CONV_B_WMASK    8'h47
`define ACC_PIN_DIS_WMASK   2'h3
`define ACC_SYNC_STAGES     2
`define ACC_PRIME_EDGES     3
`define ACC_BIT_POWER_OFF   7
`define ACC_BIT_BANDGAP     6
`define ACC_BIT_RESULT      5
`define ACC_BIT_FLAG        4
`define ACC_BIT_IRQ_EN      3
`define ACC_BIT_CAPTURE     2
`define ACC_BIT_MODE_HI     1
`define ACC_BIT_MODE_LO     0
`define ACC_BIT_MUX_EN      6
`define ACC_BIT_TRIG_HI     2
`define ACC_MODE_TOGGLE     2'h0
`define ACC_MODE_RESERVED   2'h1
`define ACC_MODE_FALL       2'h2
`define ACC_MODE_RISE       2'h3
`endif

// ===== bench/acc_control_props.sv
// Purpose: port checks for acc_control
// Assumes: bound into acc_control
// Notes: raw held 4 edges fixes the synced value
`timescale 1ns/1ns
module acc_control_props (
  input wire logic clk_in, resetn_in, wr_in, rd_in, irq_ack_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out,
  input wire logic cmp_raw_in, irq_out, global_irq_enable_in,
  input wire logic capture_route_out, capture_trigger_out,
  input wire logic cmp_neg_use_channel_out, converter_enable_in,
  input wire logic converter_power_reduce_in);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence quiet_s; $stable(cmp_raw_in)[*4]; endsequence
  result_read_a: assert property (quiet_s ##0 (rd_in && addr_in == 8'h50)
    |=> rdata_out[5] == $past(cmp_raw_in)) else $error("bad result");
  rsvd_zero_a: assert property (rd_in && addr_in == 8'h7f |=>
    rdata_out[7:2] == 6'h00) else $error("bad reserved");
  irq_gate_a: assert property (irq_out |->
    global_irq_enable_in) else $error("bad irq");
  ack_clear_a: assert property (quiet_s ##0 irq_ack_in |=>
    !irq_out) else $error("bad ack");
  flag_clear_a: assert property (quiet_s ##0 (wr_in &&
    addr_in == 8'h50 && wdata_in[4]) |=> !irq_out) else $error("bad clear");
  cap_off_a: assert property (capture_trigger_out |->
    capture_route_out) else $error("bad route");
  cap_follow_a: assert property (quiet_s ##0 capture_route_out |->
    capture_trigger_out == cmp_raw_in) else $error("bad trigger");
  mux_gate_a: assert property (cmp_neg_use_channel_out |->
    !converter_enable_in && !converter_power_reduce_in) else $error("bad mux");
endmodule // acc_control_props
bind acc_control acc_control_props u_acc_control_props (.*);

// ===== bench/acc_cmp_model.sv
// Purpose: behavioural comparator core
// Assumes: levels are 8-bit codes, negative pin fixed
// Notes: unpowered core outputs low
`timescale 1ns/1ns
module acc_cmp_model (
  input wire logic       power_off_in, bandgap_in, use_channel_in,
  input wire logic [2:0] channel_in,
  input wire logic [7:0] pos_lvl_in,
  output logic           raw_out);
  assign raw_out = !power_off_in &&
    (bandgap_in ? 8'h80 : pos_lvl_in) >
    (use_channel_in ? {channel_in, 5'h10} : 8'h7f);
endmodule // acc_cmp_model

// ===== bench/tb.sv
// Purpose: random and corner tests of acc_control
// Assumes: 100 MHz clock, model makes the raw result
// Notes: a level with msb set beats the fixed negative pin level 7f
`timescale 1ns/1ns
module tb;
  logic clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, irq_ack_in = 0;
  logic global_irq_enable_in = 0, converter_enable_in = 0, cmp_neg_pin_in = 0;
  logic converter_power_reduce_in = 0, cmp_pos_pin_in = 0, cmp_raw_in, irq_out;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, pos = 0, d, e;
  logic [2:0] channel_select_in = 0, cmp_neg_channel_out;
  logic cmp_power_off_out, cmp_pos_bandgap_out, cmp_neg_use_channel_out;
  logic pos_pin_input_off_out, neg_pin_input_off_out, pos_pin_port_bit_out;
  logic neg_pin_port_bit_out, capture_trigger_out, capture_route_out;
  integer fails = 0, compares = 0, seed = 32'h04ddda25, m;
  always #5 clk_in = ~clk_in;
  acc_control u_acc_control (.*);
  acc_cmp_model u_acc_cmp_model (.power_off_in(cmp_power_off_out),
    .bandgap_in(cmp_pos_bandgap_out), .use_channel_in(cmp_neg_use_channel_out),
    .channel_in(cmp_neg_channel_out), .pos_lvl_in(pos), .raw_out(cmp_raw_in));
  task automatic chk(input [7:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input [7:0] a, v);
    @(posedge clk_in);
    {wr_in, addr_in, wdata_in} <= {1'b1, a, v};
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task automatic rd(input [7:0] a, e, k);
    @(posedge clk_in);
    {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_in);
    rd_in <= 0;
    #1 chk(rdata_out & k, e);
  endtask
  // result bit and expected flag after one edge of kind up
  function automatic [7:0] flag_exp(input [1:0] md, input up);
    flag_exp = {2'b0, up, md == 2'h0 || md == {1'b1, up}, 4'h0};
  endfunction
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #60000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1;
    rd(8'h00, 8'h00, 8'hff);
    for (m = 0; m < 8; m++) begin
      pos <= {~m[2], 7'($random(seed))};
      repeat (5) @(posedge clk_in);
      wr(8'h50, 8'h10 | 8'(m[1:0]));
      pos <= {m[2], 7'($random(seed))};
      repeat (5) @(posedge clk_in);
      rd(8'h50, flag_exp(m[1:0], m[2]), 8'h30);
    end
    $display("edge tests done");
    global_irq_enable_in <= 1;
    wr(8'h50, 8'h18);
    pos <= ~pos;
    repeat (5) @(posedge clk_in);
    chk({7'h0, irq_out}, 8'h01);
    irq_ack_in <= 1;
    @(posedge clk_in);
    irq_ack_in <= 0;
    #1 chk({7'h0, irq_out}, 8'h00);
    pos <= ~pos;
    repeat (5) @(posedge clk_in);
    wr(8'h50, 8'h18);
    #1 chk({7'h0, irq_out}, 8'h00);
    $display("irq tests done");
    repeat (8) begin
      d = 8'($random(seed));
      {converter_enable_in, converter_power_reduce_in, channel_select_in} <= d[4:0];
      {cmp_pos_pin_in, cmp_neg_pin_in} <= d[7:6];
      wr(8'h7f, d);
      rd(8'h7f, d & 8'h03, 8'hff);
      wr(8'h7b, d);
      rd(8'h7b, d & 8'h47, 8'hff);
      wr(8'h50, d & 8'hc4);
      rd(8'h50, d & 8'hc4, 8'hc4);
      chk({7'h0, cmp_neg_use_channel_out}, {7'h0, d[6] & ~|d[4:3]});
      chk({cmp_power_off_out, cmp_pos_bandgap_out, 3'h0,
        capture_route_out, 2'h0}, d & 8'hc4);
      chk({5'h0, cmp_neg_channel_out}, {5'h0, d[2:0]});
      chk({7'h0, capture_trigger_out}, {7'h0, d[2] & cmp_raw_in});
      e = {4'h0, d[1:0], d[6] & ~d[1], d[7] & ~d[0]};
      chk({4'h0, neg_pin_input_off_out, pos_pin_input_off_out,
        neg_pin_port_bit_out, pos_pin_port_bit_out}, e);
    end
    $display("register tests done");
    pos <= 8'hff;
    resetn_in <= 0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1;
    repeat (4) @(posedge clk_in);
    rd(8'h50, 8'h20, 8'h30);
    $display("reset tests done");
    report_and_stop;
  end
endmodule // tb
